// [common/sfca_regs.vh]
// constants for the serial flash command addressing front end
// assumes inclusion by design and bench files; no processes here
`ifndef SFCA_REGS_VH
`define SFCA_REGS_VH

// opcodes
`define SFCA_OP_RD_ARRAY   8'h03
`define SFCA_OP_RD_FAST    8'h0b
`define SFCA_OP_PG_HI7     8'h50
`define SFCA_OP_PG_XFER    8'h53
`define SFCA_OP_PG_REWR    8'h58
`define SFCA_OP_PG_CMP     8'h60
`define SFCA_OP_SEC_RD     8'h77
`define SFCA_OP_PG_TOP     8'h7c
`define SFCA_OP_PG_ERASE   8'h81
`define SFCA_OP_PB_PROG    8'h82
`define SFCA_OP_BP_ERASE   8'h83
`define SFCA_OP_BUF_WR     8'h84
`define SFCA_OP_BP_NOERASE 8'h88
`define SFCA_OP_ID_RD      8'h9f
`define SFCA_OP_DPD        8'hb9
`define SFCA_OP_RESUME     8'hab
`define SFCA_OP_BUF_RD_LF  8'hd1
`define SFCA_OP_PG_RD      8'hd2
`define SFCA_OP_BUF_RD     8'hd4
`define SFCA_OP_STAT_RD    8'hd7
`define SFCA_OP_CONT_RD    8'he8

// address field positions within the 24 address bits
`define SFCA_PAGE_MSB      18
`define SFCA_PAGE_LSB      9
`define SFCA_BYTE_MSB      8
`define SFCA_BYTE_LSB      0

// address use codes
`define SFCA_USE_NONE      3'h0
`define SFCA_USE_PAGE_BYTE 3'h1
`define SFCA_USE_PAGE      3'h2
`define SFCA_USE_PAGE_HI7  3'h3
`define SFCA_USE_PAGE_TOP  3'h4
`define SFCA_USE_BYTE      3'h5
`define SFCA_USE_DONTCARE  3'h6

// reset values
`define SFCA_MODE_RESET    1'b1

// power-up timing, in microseconds, and the clock period in ns
`define SFCA_CLK_NS        40
`define SFCA_T_SEL_US      1000
`define SFCA_T_WR_US       20000
`define SFCA_SEL_CYC       ((`SFCA_T_SEL_US * 1000 + `SFCA_CLK_NS - 1) / `SFCA_CLK_NS)
`define SFCA_WR_CYC        ((`SFCA_T_WR_US * 1000) / `SFCA_CLK_NS)

`endif

// [design/sfca_decode.v]
// opcode table: address use and trailing don't-care byte count
// assumes a fully received opcode byte; purely combinational
`timescale 1ns/1ps
`include "sfca_regs.vh"

module sfca_decode (
	opcode,
	use_code,
	addr_bytes,
	dummy_bytes,
	known
);
	input  wire [7:0] opcode;
	output reg  [2:0] use_code;
	output reg  [1:0] addr_bytes;
	output reg  [2:0] dummy_bytes;
	output reg        known;

	always @* begin
		use_code    = `SFCA_USE_NONE;
		addr_bytes  = 2'h3;
		dummy_bytes = 3'h0;
		known       = 1'b1;
		case (opcode)
			`SFCA_OP_RD_ARRAY, `SFCA_OP_PB_PROG: begin
				use_code = `SFCA_USE_PAGE_BYTE;
			end
			`SFCA_OP_RD_FAST: begin
				use_code    = `SFCA_USE_PAGE_BYTE;
				dummy_bytes = 3'h1;
			end
			`SFCA_OP_PG_RD, `SFCA_OP_CONT_RD: begin
				use_code    = `SFCA_USE_PAGE_BYTE;
				dummy_bytes = 3'h4;
			end
			`SFCA_OP_PG_XFER, `SFCA_OP_PG_REWR, `SFCA_OP_PG_CMP,
			`SFCA_OP_PG_ERASE, `SFCA_OP_BP_ERASE, `SFCA_OP_BP_NOERASE: begin
				use_code = `SFCA_USE_PAGE;
			end
			`SFCA_OP_PG_HI7: begin
				use_code = `SFCA_USE_PAGE_HI7;
			end
			`SFCA_OP_PG_TOP: begin
				use_code = `SFCA_USE_PAGE_TOP;
			end
			`SFCA_OP_SEC_RD: begin
				use_code = `SFCA_USE_DONTCARE;
			end
			`SFCA_OP_ID_RD, `SFCA_OP_DPD, `SFCA_OP_RESUME, `SFCA_OP_STAT_RD: begin
				addr_bytes = 2'h0;
			end
			`SFCA_OP_BUF_WR, `SFCA_OP_BUF_RD_LF: begin
				use_code = `SFCA_USE_BYTE;
			end
			`SFCA_OP_BUF_RD: begin
				use_code    = `SFCA_USE_BYTE;
				dummy_bytes = 3'h1;
			end
			default: begin
				addr_bytes = 2'h0;
				known      = 1'b0;
			end
		endcase
	end
endmodule // sfca_decode

// [design/sfca_front.v]
// serial flash command front end: opcode, address and don't-care byte framing
// assumes sel_n, sclk, sdi come from the host pins, asynchronous to mclk;
// por_hold is high while supply is below the power-on reset threshold
//
// Notes on behaviour
// - address is 5 reserved, 10 page, 9 byte
// - read/program opcodes carry page, byte, dummy bytes
// - page-only opcodes ignore byte address positions
// - 50h,7Ch partial page; 77h don't care; none
// - buffer opcodes use byte address; D4h one dummy
// - mode 3 after power-up or reset
// - serial output tristated after power-up or reset
// - instruction accepted only after select falling edge
// - select falling edge samples clock idle level
// - below threshold, hold reset, ignore commands
// - after power-up, standby awaiting select
`timescale 1ns/1ps
`include "sfca_regs.vh"

module sfca_front #(
	parameter SEL_CYC = `SFCA_SEL_CYC,
	parameter WR_CYC  = `SFCA_WR_CYC
) (
	mclk,
	reset,
	por_hold,
	sel_n,
	sclk,
	sdi,
	sdo_out,
	sdo_oe,
	read_data,
	clk_mode3,
	cmd_valid,
	cmd_opcode,
	cmd_use,
	page_addr_bits,
	byte_addr_bits,
	dummy_done,
	cmd_busy,
	standby,
	read_ready,
	write_ready
);
	input  wire        mclk;
	input  wire        reset;
	input  wire        por_hold;
	input  wire        sel_n;
	input  wire        sclk;
	input  wire        sdi;
	output wire        sdo_out;
	output wire        sdo_oe;
	input  wire [7:0]  read_data;
	output wire        clk_mode3;
	output wire        cmd_valid;
	output wire [7:0]  cmd_opcode;
	output wire [2:0]  cmd_use;
	output wire [9:0]  page_addr_bits;
	output wire [8:0]  byte_addr_bits;
	output wire        dummy_done;
	output wire        cmd_busy;
	output wire        standby;
	output wire        read_ready;
	output wire        write_ready;

	localparam ST_IDLE  = 3'h0;
	localparam ST_OP    = 3'h1;
	localparam ST_ADDR  = 3'h2;
	localparam ST_DUMMY = 3'h3;
	localparam ST_DATA  = 3'h4;
	localparam ST_WAIT  = 3'h5;

	// two-flop synchronisers
	reg [2:0] meta_ff;
	reg [2:0] sync_ff;
	reg       sclk_d_ff;
	reg       sel_d_ff;
	wire      in_rst;
	wire      sel_fall;
	wire      sclk_rise;
	wire      sclk_fall;

	reg [2:0]  st_ff;
	reg [2:0]  nxt_st;
	reg        mode3_ff;
	reg [2:0]  bit_ff;
	reg [1:0]  bytes_ff;
	reg [2:0]  dum_ff;
	reg [7:0]  shift_ff;
	reg [7:0]  op_ff;
	reg [2:0]  use_ff;
	reg [23:0] addr_ff;
	reg        valid_ff;
	reg        dummy_done_ff;
	reg [9:0]  page_ff;
	reg [8:0]  byte_ff;
	reg        oe_ff;
	reg        sdo_ff;
	reg [7:0]  tx_ff;
	reg [19:0] pwr_cnt_ff;

	wire [2:0] dec_use;
	wire [1:0] dec_abytes;
	wire [2:0] dec_dbytes;
	wire       dec_known;
	wire [7:0] rx_byte;
	wire       byte_end;
	wire       shift_edge;
	wire       out_edge;

	sfca_decode u_dec (
		.opcode      (rx_byte),
		.use_code    (dec_use),
		.addr_bytes  (dec_abytes),
		.dummy_bytes (dec_dbytes),
		.known       (dec_known)
	);

	assign in_rst = reset | por_hold;

	always @(posedge mclk) begin
		if (in_rst) begin
			meta_ff   <= 3'h7;
			sync_ff   <= 3'h7;
			sclk_d_ff <= 1'b1;
			sel_d_ff  <= 1'b1;
		end else begin
			meta_ff   <= {sel_n, sclk, sdi};
			sync_ff   <= meta_ff;
			sclk_d_ff <= sync_ff[1];
			sel_d_ff  <= sync_ff[2];
		end
	end

	assign sel_fall  = sel_d_ff & ~sync_ff[2];
	assign sclk_rise = ~sclk_d_ff & sync_ff[1];
	assign sclk_fall = sclk_d_ff & ~sync_ff[1];
	// sampling on rising, output on falling in both modes 0 and 3
	assign shift_edge = sclk_rise;
	assign out_edge   = sclk_fall;
	assign rx_byte    = {shift_ff[6:0], sync_ff[0]};
	assign byte_end   = shift_edge & (bit_ff == 3'h7);

	// extract page and byte fields from the 24 address bits
	function [18:0] fields;
		input [2:0]  use_c;
		input [23:0] a;
		reg   [9:0]  pg;
		reg   [8:0]  by;
		begin
			pg = a[`SFCA_PAGE_MSB:`SFCA_PAGE_LSB];
			by = a[`SFCA_BYTE_MSB:`SFCA_BYTE_LSB];
			case (use_c)
				`SFCA_USE_PAGE_BYTE: fields = {pg, by};
				`SFCA_USE_PAGE:      fields = {pg, 9'h000};
				`SFCA_USE_PAGE_HI7:  fields = {pg[9:3], 3'h0, 9'h000};
				`SFCA_USE_PAGE_TOP:  fields = {pg[9], 9'h000, 9'h000};
				`SFCA_USE_BYTE:      fields = {10'h000, by};
				default:             fields = 19'h00000;
			endcase
		end
	endfunction

	always @* begin
		nxt_st = st_ff;
		case (st_ff)
			ST_IDLE: if (sel_fall) nxt_st = ST_OP;
			ST_OP: begin
				if (byte_end) begin
					if (!dec_known)
						nxt_st = ST_WAIT;
					else if (dec_abytes != 2'h0)
						nxt_st = ST_ADDR;
					else
						nxt_st = ST_DATA;
				end
			end
			ST_ADDR: begin
				if (byte_end && bytes_ff == 2'h1)
					nxt_st = (dum_ff != 3'h0) ? ST_DUMMY : ST_DATA;
			end
			ST_DUMMY: if (byte_end && dum_ff == 3'h1) nxt_st = ST_DATA;
			ST_DATA:  nxt_st = ST_DATA;
			ST_WAIT:  nxt_st = ST_WAIT;
			default:  nxt_st = ST_IDLE;
		endcase
		if (sync_ff[2])
			nxt_st = ST_IDLE;
	end

	always @(posedge mclk) begin
		if (in_rst) begin
			st_ff         <= ST_IDLE;
			mode3_ff      <= `SFCA_MODE_RESET;
			bit_ff        <= 3'h0;
			bytes_ff      <= 2'h0;
			dum_ff        <= 3'h0;
			shift_ff      <= 8'h00;
			op_ff         <= 8'h00;
			use_ff        <= `SFCA_USE_NONE;
			addr_ff       <= 24'h000000;
			valid_ff      <= 1'b0;
			dummy_done_ff <= 1'b0;
			page_ff       <= 10'h000;
			byte_ff       <= 9'h000;
		end else begin
			st_ff         <= nxt_st;
			valid_ff      <= 1'b0;
			dummy_done_ff <= 1'b0;
			if (sel_fall)
				mode3_ff <= sync_ff[1];
			if (st_ff == ST_IDLE || sync_ff[2]) begin
				bit_ff <= 3'h0;
			end else if (shift_edge) begin
				bit_ff   <= bit_ff + 3'h1;
				shift_ff <= rx_byte;
			end
			if (st_ff == ST_OP && byte_end) begin
				op_ff    <= rx_byte;
				use_ff   <= dec_use;
				bytes_ff <= dec_abytes;
				// a new command drops the old address; no-address commands leave it zero
				{page_ff, byte_ff} <= 19'h00000;
				dum_ff   <= dec_dbytes;
				if (dec_known && dec_abytes == 2'h0)
					valid_ff <= 1'b1;
			end
			if (st_ff == ST_ADDR && shift_edge)
				addr_ff <= {addr_ff[22:0], sync_ff[0]};
			if (st_ff == ST_ADDR && byte_end) begin
				bytes_ff <= bytes_ff - 2'h1;
				if (bytes_ff == 2'h1) begin
					{page_ff, byte_ff} <= fields(use_ff, {addr_ff[22:0], sync_ff[0]});
					valid_ff <= 1'b1;
				end
			end
			if (st_ff == ST_DUMMY && byte_end) begin
				dum_ff <= dum_ff - 3'h1;
				if (dum_ff == 3'h1)
					dummy_done_ff <= 1'b1;
			end
		end
	end

	// serial output: high impedance until a selected command, read or not, reaches its data phase
	always @(posedge mclk) begin
		if (in_rst) begin
			oe_ff  <= 1'b0;
			sdo_ff <= 1'b0;
			tx_ff  <= 8'h00;
		end else if (sync_ff[2] || st_ff != ST_DATA) begin
			oe_ff <= 1'b0;
			tx_ff <= read_data;
		end else if (out_edge) begin
			oe_ff  <= 1'b1;
			sdo_ff <= tx_ff[7];
			tx_ff  <= {tx_ff[6:0], 1'b0};
		end
	end

	// power-up windows the host must respect, shown as status only
	always @(posedge mclk) begin
		if (in_rst)
			pwr_cnt_ff <= 20'h00000;
		else if (pwr_cnt_ff < WR_CYC[19:0])
			pwr_cnt_ff <= pwr_cnt_ff + 20'h00001;
	end

	assign sdo_out        = sdo_ff;
	assign sdo_oe         = oe_ff;
	assign clk_mode3      = mode3_ff;
	assign cmd_valid      = valid_ff;
	assign cmd_opcode     = op_ff;
	assign cmd_use        = use_ff;
	assign page_addr_bits = page_ff;
	assign byte_addr_bits = byte_ff;
	assign dummy_done     = dummy_done_ff;
	assign cmd_busy       = (st_ff != ST_IDLE);
	assign standby        = (st_ff == ST_IDLE);
	assign read_ready     = (pwr_cnt_ff >= SEL_CYC[19:0]);
	assign write_ready    = (pwr_cnt_ff >= WR_CYC[19:0]);
endmodule // sfca_front

// [tb/sfca_host.sv]
// host serial master model: select, clock and data in
// assumes mclk of 40 ns; link clock 320 ns, low 5 and high 3 cycles
`timescale 1ns/1ps
module sfca_host (
	input  wire mclk,
	input  wire sdo,
	output reg  sel_n,
	output reg  sclk,
	output reg  sdi
);
	reg [7:0] rx_ff = 8'h00;
	initial begin
		sel_n = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
	end
	// sel low selects the device; clock stands at idle outside frames
	task frame(input [79:0] bits, input integer n, input idle, input sel);
		integer i;
		begin
			@(negedge mclk) sclk = idle;
			repeat (4) @(negedge mclk);
			sel_n = !sel;
			repeat (4) @(negedge mclk);
			for (i = n - 1; i >= 0; i = i - 1) begin
				sclk = 1'b0;
				sdi = bits[i];
				repeat (5) @(negedge mclk);
				rx_ff = {rx_ff[6:0], sdo};
				sclk = 1'b1;
				repeat (3) @(negedge mclk);
			end
			sclk = idle;
			repeat (6) @(negedge mclk);
			sel_n = 1'b1;
			sdi = !sdi;
			repeat (8) @(negedge mclk);
		end
	endtask
endmodule // sfca_host

// [tb/sfca_monitor.sv]
// checker for the command front end ports
// assumes bind onto sfca_front, one clock mclk
`timescale 1ns/1ps
`include "sfca_regs.vh"
module sfca_chk #(
	parameter SEL_CYC = 20,
	parameter WR_CYC  = 50
) (
	input wire       mclk,
	input wire       reset,
	input wire       por_hold,
	input wire       sel_n,
	input wire       sdo_oe,
	input wire       clk_mode3,
	input wire       cmd_valid,
	input wire [2:0] cmd_use,
	input wire [9:0] page_addr_bits,
	input wire [8:0] byte_addr_bits,
	input wire       dummy_done,
	input wire       cmd_busy,
	input wire       standby,
	input wire       read_ready,
	input wire       write_ready
);
	reg [19:0] cyc_ff;
	wire       rst = reset | por_hold;
	always @(posedge mclk) cyc_ff <= rst ? 20'h0 : cyc_ff + 20'h1;
	default clocking cb @(posedge mclk); endclocking
	sequence s_rst; rst; endsequence
	sequence s_desel; sel_n [*6]; endsequence
	a_reset_mode3: assert property (s_rst |=> clk_mode3)
		else $error("mode not 3 after reset");
	a_reset_hiz: assert property (s_rst |=> !sdo_oe)
		else $error("output driven after reset");
	a_reset_idle: assert property (s_rst |=> standby && !cmd_valid && !read_ready && !write_ready)
		else $error("not idle after reset");
	a_desel_hiz: assert property (disable iff (rst) s_desel |-> !sdo_oe)
		else $error("output driven while deselected");
	a_valid_pulse: assert property (disable iff (rst) cmd_valid |=> !cmd_valid)
		else $error("command pulse too long");
	a_dummy_pulse: assert property (disable iff (rst) dummy_done |=> !dummy_done)
		else $error("dummy pulse too long");
	a_valid_sel: assert property (disable iff (rst) cmd_valid |-> !$past(sel_n, 4))
		else $error("command without select");
	a_addr_mask: assert property (disable iff (rst) cmd_valid |=>
		(cmd_use != `SFCA_USE_PAGE || byte_addr_bits == 9'h000) &&
		(cmd_use != `SFCA_USE_BYTE || page_addr_bits == 10'h000) &&
		(cmd_use != `SFCA_USE_PAGE_HI7 || page_addr_bits[2:0] == 3'h0) &&
		(cmd_use != `SFCA_USE_PAGE_TOP || page_addr_bits[8:0] == 9'h000))
		else $error("unused address bits not zero");
	a_idle_busy: assert property (disable iff (rst) standby != cmd_busy)
		else $error("standby and busy disagree");
	a_read_time: assert property (disable iff (rst) $rose(read_ready) |->
		cyc_ff >= SEL_CYC - 1 && cyc_ff <= SEL_CYC + 1)
		else $error("read ready at wrong time");
	a_write_time: assert property (disable iff (rst) $rose(write_ready) |->
		cyc_ff >= WR_CYC - 1 && cyc_ff <= WR_CYC + 1)
		else $error("write ready at wrong time");
endmodule // sfca_chk
bind sfca_front sfca_chk #(.SEL_CYC(SEL_CYC), .WR_CYC(WR_CYC)) u_chk (
	.mclk(mclk), .reset(reset), .por_hold(por_hold), .sel_n(sel_n), .sdo_oe(sdo_oe),
	.clk_mode3(clk_mode3), .cmd_valid(cmd_valid), .cmd_use(cmd_use), .page_addr_bits(page_addr_bits),
	.byte_addr_bits(byte_addr_bits), .dummy_done(dummy_done), .cmd_busy(cmd_busy), .standby(standby),
	.read_ready(read_ready), .write_ready(write_ready));

// [tb/sfca_tb.sv]
// self-checking bench for the command front end
// assumes sfca_front, sfca_host and the bound checker
`timescale 1ns/1ps
`include "sfca_regs.vh"
module testbench;
	localparam SEL_CYC = 20;
	localparam WR_CYC  = 50;
	reg        mclk = 1'b0;
	reg        reset = 1'b1;
	reg        por_hold = 1'b0;
	reg  [7:0] read_data = 8'ha5;
	wire       sel_n, sclk, sdi, sdo_out, sdo_oe, clk_mode3, cmd_valid, dummy_done;
	wire       cmd_busy, standby, read_ready, write_ready;
	wire [7:0] cmd_opcode;
	wire [2:0] cmd_use;
	wire [9:0] page_addr_bits;
	wire [8:0] byte_addr_bits;
	wire       sdo_w = sdo_oe ? sdo_out : 1'bz;
	integer    fail_count = 0, checks = 0, n_valid = 0, n_dummy = 0, v0 = 0, d0 = 0, i, k;
	reg [23:0] adr;
	reg [2:0]  u;
	reg [9:0]  pg;
	// opcode, use code, don't-care byte count
	reg [15:0] rows [0:20] = '{16'h0310, 16'h0b11, 16'h5030, 16'h5320, 16'h5820, 16'h6020, 16'h7760,
		16'h7c40, 16'h8120, 16'h8210, 16'h8320, 16'h8450, 16'h8820, 16'h9f00, 16'hb900, 16'hab00,
		16'hd150, 16'hd214, 16'hd451, 16'hd700, 16'he814};
	always #20 mclk = ~mclk;
	always @(posedge mclk) begin
		if (cmd_valid === 1'b1) n_valid <= n_valid + 1;
		if (dummy_done === 1'b1) n_dummy <= n_dummy + 1;
	end
	sfca_host u_host (.mclk(mclk), .sdo(sdo_w), .sel_n(sel_n), .sclk(sclk), .sdi(sdi));
	sfca_front #(.SEL_CYC(SEL_CYC), .WR_CYC(WR_CYC)) u_dut (
		.mclk(mclk), .reset(reset), .por_hold(por_hold), .sel_n(sel_n), .sclk(sclk), .sdi(sdi),
		.sdo_out(sdo_out), .sdo_oe(sdo_oe), .read_data(read_data), .clk_mode3(clk_mode3),
		.cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_use(cmd_use), .page_addr_bits(page_addr_bits),
		.byte_addr_bits(byte_addr_bits), .dummy_done(dummy_done), .cmd_busy(cmd_busy), .standby(standby),
		.read_ready(read_ready), .write_ready(write_ready));
	task cmp(input [9:0] act, input [9:0] exp);
		begin
			checks = checks + 1;
			if (act !== exp) begin
				fail_count = fail_count + 1;
				$display("unexpected at %0t: got %h want %h", $time, act, exp);
			end
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d fail_count %0d", checks, fail_count);
			if (fail_count == 0 && checks > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	// opcode, address unless none, don't-care bytes, one data byte
	task send(input [7:0] op, input [2:0] ue, input [2:0] dum, input idle, input sel);
		reg [79:0] bits;
		integer n;
		begin
			bits = {72'h0, op};
			n = 8;
			if (ue != `SFCA_USE_NONE) begin
				bits = {bits[55:0], adr};
				n = 32;
			end
			bits = (bits << (8 * dum + 8)) | 80'h3c;
			n = n + 8 * dum + 8;
			v0 = n_valid;
			d0 = n_dummy;
			u_host.frame(bits, n, idle, sel);
		end
	endtask
	task wait_ready;
		begin
			k = 0;
			while (write_ready !== 1'b1 && k < 200) begin
				@(negedge mclk);
				k = k + 1;
			end
			cmp(read_ready, 1);
		end
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		fail_count = fail_count + 1;
		stop_test;
	end
	initial begin
		repeat (20) @(negedge mclk);
		reset = 1'b0;
		cmp(read_ready, 0);
		cmp(standby, 1);
		cmp(sdo_oe, 0);
		cmp(clk_mode3, 1);
		wait_ready;
		for (i = 0; i < 21; i = i + 1) begin
			adr = {5'h00, 10'h2a5 ^ i[9:0], 9'h15a ^ i[8:0]};
			u = rows[i][6:4];
			send(rows[i][15:8], u, rows[i][2:0], i[0], 1'b1);
			pg = (u == 1 || u == 2) ? adr[18:9] : (u == 3) ? adr[18:9] & 10'h3f8 :
				(u == 4) ? adr[18:9] & 10'h200 : 10'h000;
			cmp(cmd_opcode, rows[i][15:8]);
			cmp(cmd_use, u);
			cmp(page_addr_bits, pg);
			cmp(byte_addr_bits, (u == 1 || u == 5) ? adr[8:0] : 9'h000);
			cmp(n_valid - v0, 1);
			cmp(n_dummy - d0, rows[i][2:0] != 0);
			cmp(clk_mode3, i[0]);
			if (rows[i][15:8] == 8'h03) cmp(u_host.rx_ff, read_data);
		end
		send(8'h03, 3'h1, 3'h0, 1'b1, 1'b0);
		cmp(n_valid - v0, 0);
		cmp(sdo_oe, 0);
		send(8'h54, 3'h0, 3'h0, 1'b1, 1'b1);
		cmp(n_valid - v0, 0);
		@(negedge mclk) por_hold = 1'b1;
		send(8'h03, 3'h1, 3'h0, 1'b0, 1'b1);
		cmp(n_valid - v0, 0);
		cmp(standby, 1);
		cmp(read_ready, 0);
		cmp(clk_mode3, 1);
		por_hold = 1'b0;
		wait_ready;
		send(8'hd7, 3'h0, 3'h0, 1'b0, 1'b1);
		cmp(n_valid - v0, 1);
		cmp(clk_mode3, 0);
		stop_test;
	end
endmodule // testbench
